// ==== dv/windowed_watchdog_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb;
  import wdt_pkg::*;
  // short tick keeps every period within a few thousand cycles
  localparam int TK = 4;

  logic        i_clock;
  logic        i_rst;
  logic        i_write;
  logic        i_read;
  logic        idle;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic [4:0]  ev;
  logic [31:0] o_rdata;
  logic        o_watchdog_reset;
  logic        o_wake;
  logic        o_osc_enable;
  logic        o_irq;
  logic        rd_pend = 1'b0;
  logic [31:0] expq[$];
  int          num_errors;
  int          tests_run;
  int          cyc = 0;
  int          nrst = 0;
  int          nwake = 0;
  int          pre_t[5]  = '{0, 1, 0, 0, 1};
  int          code_t[5] = '{0, 0, 2, 3, 1};
  int          open_t[4] = '{2, 4, 5, 6};
  logic [31:0] d;

  watchdog_timer #(.TICK_CYCLES(TK)) DUT (
    .i_clock             (i_clock),
    .i_rst               (i_rst),
    .i_addr              (i_addr),
    .i_wdata             (i_wdata),
    .i_write             (i_write),
    .i_read              (i_read),
    .o_rdata             (o_rdata),
    .i_device_reset      (ev[0]),
    .i_clock_switch_done (ev[1]),
    .i_clear_instr       (ev[2]),
    .i_power_save_instr  (ev[3]),
    .i_power_save_idle   (idle),
    .i_wake_other        (ev[4]),
    .o_watchdog_reset    (o_watchdog_reset),
    .o_wake              (o_wake),
    .o_osc_enable        (o_osc_enable),
    .o_irq               (o_irq)
  );

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_watchdog_reset === 1'b1) nrst <= nrst + 1;
    if (o_wake === 1'b1) nwake <= nwake + 1;
    if (rd_pend === 1'b1) check("rdata", o_rdata, expq.pop_front());
    rd_pend <= i_read;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    expq.push_back(e);
    @(posedge i_clock);
    i_read <= 1'b0;
  endtask

  task automatic pulse(input int b);
    @(posedge i_clock);
    ev <= 5'h01 << b;
    @(posedge i_clock);
    ev <= 5'h00;
  endtask

  // pin is read after the falling edge, once the last write has landed
  task automatic pin(input string nm, input logic e);
    logic v;
    @(negedge i_clock);
    v = (nm == "irq") ? o_irq : o_osc_enable;
    check(nm, {31'h0, v}, {31'h0, e});
  endtask

  // tick phase is free running, so allow a few cycles either way
  task automatic fire(input int per, input bit wake);
    int t0;
    int n0;
    int w0;
    t0 = cyc;
    n0 = nrst;
    w0 = nwake;
    while (nrst == n0 && nwake == w0 && cyc - t0 < per + 16)
      @(posedge i_clock);
    repeat (2) @(posedge i_clock);
    check("period", {31'h0, (cyc - t0 >= per - 2 && cyc - t0 <= per + 12)},
          32'h0000_0001);
    check("kind", {30'h0, (nwake - w0 == 1), (nrst - n0 == 1)},
          wake ? 32'h0000_0002 : 32'h0000_0001);
  endtask

  function automatic logic [31:0] cfg(input logic fx, input logic wd,
                                      input logic pr, input logic [3:0] cd,
                                      input logic [1:0] wn);
    return {22'h0, wn, fx, wd, 1'b0, pr, cd};
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    int n0;
    i_rst = 1'b1;
    i_write = 1'b0;
    i_read = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    ev = 5'h00;
    idle = 1'b0;
    num_errors = 0;
    tests_run = 0;
    void'($urandom(32'h124b9f7e));
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(REG_CONFIG, CFG_RESET);
    rd(REG_RESET_CTRL, 32'h0000_0000);
    rd(REG_IRQ_MASK, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    pin("osc", 1'b1);
    wr(REG_CONFIG, cfg(0, 1, 0, 4'h0, 2'h0));
    pin("osc", 1'b0);
    repeat (150) @(posedge i_clock);
    rd(REG_COUNT, 32'h0000_0000);
    // prescale and postscale settings against measured period
    for (int i = 0; i < 5; i++) begin
      wr(REG_CONFIG, cfg(0, 1, pre_t[i][0], code_t[i][3:0], 2'h0));
      wr(REG_RESET_CTRL, 32'h0000_0020);
      pin("osc", 1'b1);
      fire(((pre_t[i] ? 128 : 32) << code_t[i]) * TK - 1, 0);
      rd(REG_RESET_CTRL, 32'h0000_0010);
      rd(REG_IRQ_STATUS, 32'h0000_0001);
      pin("irq", 1'b0);
      wr(REG_IRQ_STATUS, 32'h0000_0007);
    end
    wr(REG_RESET_CTRL, 32'h0000_0010);
    rd(REG_RESET_CTRL, 32'h0000_0010);
    wr(REG_RESET_CTRL, 32'h0000_0000);
    rd(REG_RESET_CTRL, 32'h0000_0000);
    wr(REG_CONFIG, cfg(1, 1, 0, 4'h0, 2'h0));
    fire(32 * TK - 1, 0);
    rd(REG_RESET_CTRL, 32'h0000_0010);
    wr(REG_CONFIG, cfg(0, 1, 0, 4'h0, 2'h0));
    wr(REG_RESET_CTRL, 32'h0000_0020);
    // periodic clears and clock switches keep it from expiring
    n0 = nrst;
    for (int k = 1; k < 3; k++) begin
      repeat (4) begin
        repeat (100) @(posedge i_clock);
        pulse(k);
      end
    end
    check("no_reset", nrst - n0, 32'h0000_0000);
    pulse(0);
    rd(REG_RESET_CTRL, 32'h0000_0000);
    // windowed mode: one early clear, then one inside the window
    for (int w = 0; w < 4; w++) begin
      wr(REG_CONFIG, cfg(0, 0, 0, 4'h3, w[1:0]));
      wr(REG_RESET_CTRL, 32'h0000_0020);
      n0 = nrst;
      repeat ((open_t[w] - 1) * 32 * TK + 64) @(posedge i_clock);
      pulse(2);
      repeat (3) @(posedge i_clock);
      check("early", nrst - n0, 32'h0000_0001);
      rd(REG_RESET_CTRL, 32'h0000_0010);
      wr(REG_IRQ_STATUS, 32'h0000_0007);
      wr(REG_RESET_CTRL, 32'h0000_0020);
      n0 = nrst;
      repeat (open_t[w] * 32 * TK + 64) @(posedge i_clock);
      pulse(2);
      repeat (3) @(posedge i_clock);
      check("legal", nrst - n0, 32'h0000_0000);
      wr(REG_RESET_CTRL, 32'h0000_0000);
    end
    // sleep then idle: timeout wakes instead of resetting
    wr(REG_CONFIG, cfg(0, 1, 0, 4'h0, 2'h0));
    wr(REG_IRQ_MASK, 32'h0000_0002);
    for (int m = 0; m < 2; m++) begin
      wr(REG_RESET_CTRL, 32'h0000_0020);
      repeat (60) @(posedge i_clock);
      idle <= m[0];
      pulse(3);
      fire(32 * TK - 1, 1);
      rd(REG_RESET_CTRL, m ? 32'h0000_0034 : 32'h0000_0038);
      pin("irq", 1'b1);
      wr(REG_RESET_CTRL, 32'h0000_0020);
      rd(REG_RESET_CTRL, 32'h0000_0020);
      wr(REG_IRQ_STATUS, 32'h0000_0007);
      pin("irq", 1'b0);
      wr(REG_RESET_CTRL, 32'h0000_0000);
    end
    repeat (6) begin
      d = $urandom;
      wr(REG_IRQ_MASK, d);
      rd(REG_IRQ_MASK, d & 32'h0000_0007);
    end
    repeat (4) @(posedge i_clock);
    wrap_up();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (40000) @(posedge i_clock);
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== rtl/low_power_rc_osc.sv ====
`timescale 1ns/1ps
`default_nettype none
module low_power_rc_osc #(
  parameter int TICK_CYCLES = wdt_pkg::OSC_TICK_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_enable,
  output var  logic o_tick
);
  import wdt_pkg::*;
  localparam int CNT_W = $clog2(TICK_CYCLES);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

  logic [CNT_W-1:0] count;
  wire              wrap = i_enable & (count == LAST);

  // stopped oscillator restarts a full period, no stale half tick
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= wrap;
      if (!i_enable || wrap) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/watchdog_timer.sv ====
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer #(
  parameter int TICK_CYCLES = wdt_pkg::OSC_TICK_CYCLES
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  input  wire logic [wdt_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [wdt_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_write,
  input  wire logic                       i_read,
  output var  logic [wdt_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                       i_device_reset,
  input  wire logic                       i_clock_switch_done,
  input  wire logic                       i_clear_instr,
  input  wire logic                       i_power_save_instr,
  input  wire logic                       i_power_save_idle,
  input  wire logic                       i_wake_other,
  output var  logic                       o_watchdog_reset,
  output var  logic                       o_wake,
  output var  logic                       o_osc_enable,
  output var  logic                       o_irq
);
  import wdt_pkg::*;

  logic [31:0]       cfg;
  logic              sw_on;
  logic              timeout_flag;
  logic              sleep_flag;
  logic              idle_flag;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [PRE_W-1:0]  pre_count;
  logic [POST_W-1:0] post_count;
  pm_state_t         state;
  pm_state_t         next_state;
  logic              osc_tick;

  // register decode
  wire wr_cfg    = i_write & (i_addr == REG_CONFIG);
  wire wr_rc     = i_write & (i_addr == REG_RESET_CTRL);
  wire wr_status = i_write & (i_addr == REG_IRQ_STATUS);
  wire wr_mask   = i_write & (i_addr == REG_IRQ_MASK);

  // configuration fields
  wire [3:0] post_sel  = cfg[CFG_POST_LSB +: 4];
  wire       pre_sel   = cfg[CFG_PRE_BIT];
  wire       windowed  = ~cfg[CFG_WIN_OFF_BIT];
  wire       fixed_on  = cfg[CFG_FIXED_BIT];
  wire [1:0] win_sel   = cfg[CFG_WIN_LSB +: 2];

  wire wd_enabled = fixed_on | sw_on;
  wire in_run     = (state == ST_RUN);

  // divider chain terminal counts
  wire [PRE_W-1:0] pre_term =
    pre_sel ? PRE_LONG_LAST : PRE_SHORT_LAST;
  wire [POST_W-1:0] post_term = post_last(post_sel);
  wire [POST_W-1:0] open_at = win_open(win_sel, post_sel);
  wire pre_last  = (pre_count == pre_term);
  wire post_tick = osc_tick & pre_last;
  wire timeout   = wd_enabled & post_tick & (post_count == post_term);

  // core events
  wire clear_req   = i_clear_instr & in_run;
  wire win_violate = clear_req & windowed & wd_enabled
                     & (post_count < open_at);
  wire dog_reset   = in_run & (timeout | win_violate);
  wire wake        = ~in_run & timeout;
  wire enter_ps    = in_run & i_power_save_instr;
  wire leave_ps    = ~in_run & (i_wake_other | timeout);
  wire any_reset   = i_device_reset | dog_reset;

  // every source that zeroes the counter and both dividers
  wire chain_clear = any_reset | i_clock_switch_done
                     | enter_ps | leave_ps
                     | clear_req
                     | ~wd_enabled;

  low_power_rc_osc #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_osc (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_enable (o_osc_enable),
    .o_tick   (osc_tick)
  );

  assign o_osc_enable = wd_enabled;
  assign o_irq        = |(irq_status & irq_mask);

  // counter chain advances only on oscillator ticks
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pre_count  <= '0;
      post_count <= '0;
    end else if (chain_clear) begin
      pre_count  <= '0;
      post_count <= '0;
    end else if (osc_tick) begin
      pre_count <= pre_last ? '0 : pre_count + 1'b1;
      if (pre_last) begin
        post_count <= (post_count == post_term) ? '0
                      : post_count + 1'b1;
      end
    end
  end

  // power-save state; the watchdog keeps counting in both
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (enter_ps) begin
          next_state = i_power_save_idle ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_SLEEP, ST_IDLE: begin
        if (leave_ps) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (i_device_reset) begin
      next_state = ST_RUN;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // config is fuse-backed; software may load it like a fuse image
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cfg <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= i_wdata & CFG_MASK;
    end
  end

  // software enable: any reset wins over a write
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sw_on <= 1'b0;
    end else if (any_reset) begin
      sw_on <= 1'b0;
    end else if (wr_rc) begin
      sw_on <= i_wdata[RC_SW_ON_BIT];
    end
  end

  // sticky flags: hardware set wins over a software clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      timeout_flag <= 1'b0;
      sleep_flag   <= 1'b0;
      idle_flag    <= 1'b0;
    end else begin
      if (timeout | win_violate) begin
        timeout_flag <= 1'b1;
      end else if (wr_rc && !i_wdata[RC_TIMEOUT_BIT]) begin
        timeout_flag <= 1'b0;
      end
      if (enter_ps && !i_power_save_idle) begin
        sleep_flag <= 1'b1;
      end else if (wr_rc && !i_wdata[RC_SLEEP_BIT]) begin
        sleep_flag <= 1'b0;
      end
      if (enter_ps && i_power_save_idle) begin
        idle_flag <= 1'b1;
      end else if (wr_rc && !i_wdata[RC_IDLE_BIT]) begin
        idle_flag <= 1'b0;
      end
    end
  end

  // interrupt status, write one to clear, events win
  wire [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_TIMEOUT] = timeout;
  assign irq_event[IRQ_WAKE]    = wake;
  assign irq_event[IRQ_WINDOW]  = win_violate;

  wire [IRQ_W-1:0] irq_clear =
    wr_status ? i_wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
      if (wr_mask) begin
        irq_mask <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  // one-cycle pulses to the reset controller and core
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_watchdog_reset <= 1'b0;
      o_wake           <= 1'b0;
    end else begin
      o_watchdog_reset <= dog_reset;
      o_wake           <= wake;
    end
  end

  // read path
  wire [31:0] rc_word = {26'h000_0000, sw_on, timeout_flag,
                         sleep_flag, idle_flag, 2'h0};
  wire [31:0] count_word = {9'h000, pre_count, post_count};
  wire [31:0] next_rdata =
    (i_addr == REG_CONFIG)     ? cfg :
    (i_addr == REG_RESET_CTRL) ? rc_word :
    (i_addr == REG_IRQ_STATUS) ? {29'h0000_0000, irq_status} :
    (i_addr == REG_IRQ_MASK)   ? {29'h0000_0000, irq_mask} :
    (i_addr == REG_COUNT)      ? count_word : 32'h0000_0000;

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_read ? next_rdata : '0;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  property p_tick_needs_osc;
    osc_tick |-> $past(o_osc_enable);
  endproperty
  a_tick_needs_osc: assert property (p_tick_needs_osc)
    else $error("oscillator tick while oscillator off");

  property p_pre_short;
    osc_tick && !chain_clear && !pre_sel && pre_count == PRE_SHORT_LAST
      |=> pre_count == 7'h00;
  endproperty
  a_pre_short: assert property (p_pre_short)
    else $error("divide by 32 prescaler did not wrap");

  property p_pre_long;
    osc_tick && !chain_clear && pre_sel && pre_count == PRE_SHORT_LAST
      && !wr_cfg |=> pre_count == 7'h20;
  endproperty
  a_pre_long: assert property (p_pre_long)
    else $error("divide by 128 prescaler wrapped early");

  property p_full_period;
    wd_enabled && post_tick && post_count == post_last(post_sel)
      |=> (o_watchdog_reset || o_wake);
  endproperty
  a_full_period: assert property (p_full_period)
    else $error("postscaler terminal count gave no timeout");

  property p_switch_clear;
    i_clock_switch_done |=> pre_count == 7'h00 && post_count == 16'h0000;
  endproperty
  a_switch_clear: assert property (p_switch_clear)
    else $error("clock switch did not clear watchdog");

  property p_ps_entry;
    enter_ps |=> !in_run && post_count == 16'h0000 && pre_count == 7'h00;
  endproperty
  a_ps_entry: assert property (p_ps_entry)
    else $error("power save entry did not clear watchdog");

  property p_clear_instr;
    clear_req && !win_violate |=> post_count == 16'h0000
      && pre_count == 7'h00 && !o_watchdog_reset;
  endproperty
  a_clear_instr: assert property (p_clear_instr)
    else $error("clear instruction did not zero watchdog");

  sequence s_ps_timeout;
    !in_run && timeout;
  endsequence
  sequence s_woken;
    o_wake && !o_watchdog_reset && in_run ##1 !o_wake;
  endsequence
  property p_wake;
    s_ps_timeout |=> s_woken;
  endproperty
  a_wake: assert property (p_wake)
    else $error("timeout in power save did not wake core");

  property p_fixed_on;
    fixed_on && !wr_cfg |=> o_osc_enable;
  endproperty
  a_fixed_on: assert property (p_fixed_on)
    else $error("fixed-on watchdog was stopped");

  property p_sw_reset;
    any_reset |=> !sw_on;
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("software enable survived device reset");

  property p_flag_sticky;
    timeout_flag && !(wr_rc && !i_wdata[RC_TIMEOUT_BIT]) |=> timeout_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("timeout flag cleared by hardware");

  sequence s_early_clear;
    clear_req && windowed && wd_enabled && post_count < open_at;
  endsequence
  property p_window;
    s_early_clear |=> o_watchdog_reset && timeout_flag ##1 !o_watchdog_reset;
  endproperty
  a_window: assert property (p_window)
    else $error("early windowed clear not punished");

  property p_window_size;
    post_sel == 4'hf && win_sel == WIN_25 |-> open_at == 16'h6000;
  endproperty
  a_window_size: assert property (p_window_size)
    else $error("25 percent window opens at wrong count");

  property p_post_code;
    post_sel == 4'he |-> post_term == 16'h3fff;
  endproperty
  a_post_code: assert property (p_post_code)
    else $error("postscale code 14 not 1:16384");

  property p_run_reset;
    in_run && timeout |=> o_watchdog_reset && timeout_flag && !o_wake;
  endproperty
  a_run_reset: assert property (p_run_reset)
    else $error("running timeout did not reset device");
endmodule
`default_nettype wire

// ==== rtl/wdt_pkg.sv ====
// Operation
// - watchdog counts low-power oscillator, enable starts it
// - prescaler divides by 32 or 128
// - postscaler divides by sixteen ratios, 1:1..1:32768
// - device reset, clock switch clear all counts
// - power-save entry and exit clear all counts
// - clear instruction zeroes counter and both dividers
// - runs in sleep/idle; timeout wakes core
// - fixed-on fuse keeps watchdog always running
// - else software bit enables; device reset clears it
// - timeout flag sticky until software clears it
// - window-disable zero selects windowed clear mode
// - window field: 25, 37.5, 50, 75 percent
// - prescale select one gives 128, zero 32
// - postscale code n gives ratio two to n
package wdt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] REG_CONFIG     = 8'h00;
  localparam logic [7:0] REG_RESET_CTRL = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
  localparam logic [7:0] REG_COUNT      = 8'h10;

  // watchdog_config_word layout
  localparam int CFG_POST_LSB   = 0;
  localparam int CFG_PRE_BIT    = 4;
  localparam int CFG_WIN_OFF_BIT = 6;
  localparam int CFG_FIXED_BIT  = 7;
  localparam int CFG_WIN_LSB    = 8;
  localparam logic [31:0] CFG_MASK  = 32'h0000_03df;
  localparam logic [31:0] CFG_RESET = 32'h0000_03df;

  // reset_control_reg layout
  localparam int RC_IDLE_BIT    = 2;
  localparam int RC_SLEEP_BIT   = 3;
  localparam int RC_TIMEOUT_BIT = 4;
  localparam int RC_SW_ON_BIT   = 5;

  localparam int IRQ_W          = 3;
  localparam int IRQ_TIMEOUT    = 0;
  localparam int IRQ_WAKE       = 1;
  localparam int IRQ_WINDOW     = 2;

  localparam int PRE_W  = 7;
  localparam int POST_W = 16;
  localparam logic [6:0] PRE_SHORT_LAST = 7'h1f;
  localparam logic [6:0] PRE_LONG_LAST  = 7'h7f;

  localparam logic [1:0] WIN_25  = 2'h3;
  localparam logic [1:0] WIN_37P = 2'h2;
  localparam logic [1:0] WIN_50  = 2'h1;
  localparam logic [1:0] WIN_75  = 2'h0;

  localparam int CLOCK_HZ         = 125_000_000;
  localparam int OSC_HZ           = 32_000;
  localparam int OSC_TICK_CYCLES  = CLOCK_HZ / OSC_HZ;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_IDLE  = 2'b10
  } pm_state_t;

  // postscaler ratio is two to the code, terminal count one less
  function automatic logic [15:0] post_last(input logic [3:0] sel);
    logic [15:0] n;
    n = 16'h0001 << sel;
    return n - 16'h0001;
  endfunction

  // count at which a windowed clear becomes legal
  function automatic logic [15:0] win_open(input logic [1:0] win,
                                           input logic [3:0] sel);
    logic [15:0] n;
    n = 16'h0001 << sel;
    case (win)
      WIN_25:  win_open = n - (n >> 2);
      WIN_37P: win_open = n - (n >> 2) - (n >> 3);
      WIN_50:  win_open = n >> 1;
      default: win_open = n >> 2;
    endcase
  endfunction
endpackage
